// >>> hw/gas_alarm_cfg.svh
// constants for the gas alarm and safety interlock block
`ifndef GAS_ALARM_CFG_SVH
`define GAS_ALARM_CFG_SVH
`define GA_CLK_HZ        125000000
`define GA_HOLD_S        5
`define GA_HOLD_CYC      (`GA_CLK_HZ * `GA_HOLD_S)
`define GA_BLINK_MS      500
`define GA_BLINK_CYC     ((`GA_CLK_HZ / 1000) * `GA_BLINK_MS)
`define GA_NO_MARGIN     5
`define GA_NO2_MARGIN    1
`define GA_OFS_CTRL      4'h0
`define GA_OFS_NO_HI     4'h4
`define GA_OFS_NO_LO     4'h8
`define GA_OFS_NO2_HI    4'hc
`define GA_OFS_STATUS    5'h10
`define GA_CTRL_RST      32'h0000_0000
`define GA_NO_HI_RST     16'h0050
`define GA_NO_LO_RST     16'h0000
`define GA_NO2_HI_RST    16'h0005
`define GA_ST_HI_NO      0
`define GA_ST_LO_NO      1
`define GA_ST_HI_NO2     2
`define GA_ST_SHUT       3
`define GA_ST_OVR        4
`define GA_ST_CAUSE_NO2  5
`define GA_CTRL_FORCE_QUIET 0
`endif

// >>> hw/gas_alarm_pkg.sv
// types shared by the gas alarm block
`default_nettype none
package gas_alarm_pkg;
   typedef enum logic [1:0] {
      SAFE_NORMAL   = 2'b00,
      SAFE_SHUTOFF  = 2'b01,
      SAFE_OVERRIDE = 2'b10
   } safe_state_type;
   typedef enum logic [1:0] {
      DISP_READINGS = 2'b00,
      DISP_SHUTOFF  = 2'b01,
      DISP_OVERRIDE = 2'b10
   } disp_msg_type;
endpackage
`default_nettype wire

// >>> hw/gas_alarm_safety_interlock.sv
// alarm comparators, safety shutoff and override for the gas delivery unit
// Notes on behaviour
// - NO2 at or above upper threshold alarms
// - high alarm clears when threshold exceeds reading
// - NO at or above upper threshold alarms
// - NO at or below lower threshold alarms
// - low alarm clears when threshold below reading
// - NO five ppm over upper: shutoff, beep
// - NO2 one ppm over upper: shutoff, beep
// - shutoff display alternates message and readings
// - shutoff stops all delivery gas flow
// - NO shutoff: back plus silence five seconds
// - no override message before full hold
// - NO2 shutoff: both silence buttons five seconds
// - override display alternates message and readings
// - override resumes delivery despite exceeded threshold
// - power cycle clears override, restores safety
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gas_alarm_cfg.svh"
module gas_alarm_safety_interlock
   import gas_alarm_pkg::*;
#(
   parameter int unsigned HOLD_CYC  = `GA_HOLD_CYC,
   parameter int unsigned BLINK_CYC = `GA_BLINK_CYC,
   parameter int unsigned PPM_W     = 16
) (
   input  wire logic              i_ref_clk,      // 125 MHz clock
   input  wire logic              i_arst_n,       // async reset, low
   input  wire logic [PPM_W-1:0]  i_no_ppm,       // displayed NO reading
   input  wire logic [PPM_W-1:0]  i_no2_ppm,      // displayed NO2 reading
   input  wire logic              i_btn_back,     // back button, high held
   input  wire logic              i_btn_sil_no,   // NO alarm silence button
   input  wire logic              i_btn_sil_no2,  // NO2 alarm silence button
   input  wire logic [3:0]        i_avs_address,  // word address
   input  wire logic              i_avs_read,     // read strobe
   input  wire logic              i_avs_write,    // write strobe
   input  wire logic [31:0]       i_avs_writedata,// write data
   input  wire logic [3:0]        i_avs_byteenable,// byte lanes
   output logic [31:0]            o_avs_readdata, // read data
   output logic                   o_avs_waitrequest,// stall
   output logic                   o_audible,      // buzzer on
   output logic                   o_visual,       // alarm lamp on
   output logic                   o_delivery_en,  // delivery valve open
   output logic [1:0]             o_disp_msg      // display selection
);
   localparam logic [PPM_W-1:0] NO_MARGIN  = PPM_W'(`GA_NO_MARGIN);
   localparam logic [PPM_W-1:0] NO2_MARGIN = PPM_W'(`GA_NO2_MARGIN);

   // byte merge serves at most two lanes of threshold
   if (PPM_W < 4 || PPM_W > 16) begin : g_bad_width
      $error("PPM_W out of range");
   end
   if (HOLD_CYC < 2 || BLINK_CYC < 2) begin : g_bad_count
      $error("counts too small");
   end

   // reading passes threshold by margin, without wrap
   function automatic logic over_by(input logic [PPM_W-1:0] rd,
                                    input logic [PPM_W-1:0] th,
                                    input logic [PPM_W-1:0] m);
      logic [PPM_W:0] lim;
      lim = {1'b0, th} + {1'b0, m};
      return {1'b0, rd} >= lim;
   endfunction

   // ---------------- register file ----------------
   logic [PPM_W-1:0] no_hi_reg, no_lo_reg, no2_hi_reg;
   logic             quiet_reg;
   logic             ack_reg;
   logic [31:0]      rdata_next;
   logic [31:0]      status_w;
   logic             acc;

   assign acc = (i_avs_read || i_avs_write) && !ack_reg;

   // one wait cycle, answer on the second edge
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= !acc;
      end
   end

   function automatic logic [PPM_W-1:0] merge(input logic [PPM_W-1:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] be);
      logic [31:0] w;
      w = {16'h0000, 16'(old)};
      if (be[0]) w[7:0] = d[7:0];
      if (be[1]) w[15:8] = d[15:8];
      return w[PPM_W-1:0];
   endfunction

   // thresholds are operator settings; the write takes effect on the ack edge
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         no_hi_reg  <= PPM_W'(`GA_NO_HI_RST);
         no_lo_reg  <= PPM_W'(`GA_NO_LO_RST);
         no2_hi_reg <= PPM_W'(`GA_NO2_HI_RST);
         quiet_reg  <= 1'b0;
      end else if (!o_avs_waitrequest && i_avs_write) begin
         case ({i_avs_address, 2'b00})
            6'(`GA_OFS_CTRL): begin
               if (i_avs_byteenable[0])
                  quiet_reg <= i_avs_writedata[`GA_CTRL_FORCE_QUIET];
            end
            6'(`GA_OFS_NO_HI):
               no_hi_reg <= merge(no_hi_reg, i_avs_writedata, i_avs_byteenable);
            6'(`GA_OFS_NO_LO):
               no_lo_reg <= merge(no_lo_reg, i_avs_writedata, i_avs_byteenable);
            6'(`GA_OFS_NO2_HI):
               no2_hi_reg <= merge(no2_hi_reg, i_avs_writedata,
                                   i_avs_byteenable);
            default: begin
            end
         endcase
      end
   end

   // ---------------- alarm comparators ----------------
   logic hi_no_reg, lo_no_reg, hi_no2_reg;
   logic shut_no_reg, shut_no2_reg;

   // registered compare: alarm follows threshold edits, so raising the
   // upper limit to reading+1 clears it in one cycle
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hi_no_reg    <= 1'b0;
         lo_no_reg    <= 1'b0;
         hi_no2_reg   <= 1'b0;
         shut_no_reg  <= 1'b0;
         shut_no2_reg <= 1'b0;
      end else begin
         hi_no2_reg   <= i_no2_ppm >= no2_hi_reg;
         hi_no_reg    <= i_no_ppm >= no_hi_reg;
         lo_no_reg    <= i_no_ppm <= no_lo_reg;
         shut_no_reg  <= over_by(i_no_ppm, no_hi_reg, NO_MARGIN);
         shut_no2_reg <= over_by(i_no2_ppm, no2_hi_reg, NO2_MARGIN);
      end
   end

   // ---------------- safety state machine ----------------
   safe_state_type state_reg, state_next;
   logic           cause_no2_reg;
   logic [31:0]    hold_cnt_reg;
   logic           hold_pair;
   logic           hold_done;

   // which pair of buttons depends on the gas that tripped the shutoff
   assign hold_pair = cause_no2_reg ? (i_btn_sil_no && i_btn_sil_no2)
                                    : (i_btn_back && i_btn_sil_no);
   assign hold_done = hold_cnt_reg == HOLD_CYC - 1;

   // counter clears on any release so a broken hold never accumulates
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_cnt_reg <= '0;
      end else if (state_reg != SAFE_SHUTOFF || !hold_pair) begin
         hold_cnt_reg <= '0;
      end else if (!hold_done) begin
         hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SAFE_NORMAL:
            if (shut_no_reg || shut_no2_reg) state_next = SAFE_SHUTOFF;
         SAFE_SHUTOFF:
            if (hold_pair && hold_done) state_next = SAFE_OVERRIDE;
         SAFE_OVERRIDE:
            state_next = SAFE_OVERRIDE;  // only reset leaves
         default:
            state_next = SAFE_SHUTOFF;
      endcase
   end

   // override latches until power cycle; shutoff is also latched so the
   // operator must act rather than the flow restarting on a noisy dip
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= SAFE_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cause_no2_reg <= 1'b0;
      end else if (state_reg == SAFE_NORMAL && state_next == SAFE_SHUTOFF) begin
         cause_no2_reg <= !shut_no_reg;
      end
   end

   // ---------------- display alternation ----------------
   logic [31:0] blink_cnt_reg;
   logic        phase_reg;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         blink_cnt_reg <= '0;
         phase_reg     <= 1'b0;
      end else if (state_reg == SAFE_NORMAL) begin
         blink_cnt_reg <= '0;
         phase_reg     <= 1'b0;
      end else if (blink_cnt_reg == BLINK_CYC - 1) begin
         blink_cnt_reg <= '0;
         phase_reg     <= !phase_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end

   // ---------------- outputs ----------------
   logic alarm_any;
   assign alarm_any = hi_no_reg || lo_no_reg || hi_no2_reg;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_audible     <= 1'b0;
         o_visual      <= 1'b0;
         o_delivery_en <= 1'b0;
         o_disp_msg    <= DISP_READINGS;
      end else begin
         o_visual      <= alarm_any;
         // quiet mutes plain alarms only; a shutoff always beeps
         o_audible     <= (!quiet_reg && alarm_any) ||
                          state_reg == SAFE_SHUTOFF;
         o_delivery_en <= state_reg != SAFE_SHUTOFF;
         case (state_reg)
            SAFE_SHUTOFF:
               o_disp_msg <= phase_reg ? DISP_READINGS : DISP_SHUTOFF;
            SAFE_OVERRIDE:
               o_disp_msg <= phase_reg ? DISP_READINGS : DISP_OVERRIDE;
            default:
               o_disp_msg <= DISP_READINGS;
         endcase
      end
   end

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[`GA_ST_HI_NO]     = hi_no_reg;
      status_w[`GA_ST_LO_NO]     = lo_no_reg;
      status_w[`GA_ST_HI_NO2]    = hi_no2_reg;
      status_w[`GA_ST_SHUT]      = state_reg == SAFE_SHUTOFF;
      status_w[`GA_ST_OVR]       = state_reg == SAFE_OVERRIDE;
      status_w[`GA_ST_CAUSE_NO2] = cause_no2_reg;
      case ({i_avs_address, 2'b00})
         6'(`GA_OFS_CTRL):   rdata_next = {31'h0, quiet_reg};
         6'(`GA_OFS_NO_HI):  rdata_next = 32'(no_hi_reg);
         6'(`GA_OFS_NO_LO):  rdata_next = 32'(no_lo_reg);
         6'(`GA_OFS_NO2_HI): rdata_next = 32'(no2_hi_reg);
         6'(`GA_OFS_STATUS): rdata_next = status_w;
         default:            rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (acc && i_avs_read) begin
         o_avs_readdata <= rdata_next;
      end
   end

   // ---------------- assertions ----------------
   a_no2_hi_alarm: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_no2_ppm >= no2_hi_reg) |=> ##1 o_visual)
      else $error("NO2 high alarm missing");
   a_hi_clear: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_no_ppm < no_hi_reg && i_no_ppm > no_lo_reg && i_no2_ppm < no2_hi_reg)
      |=> ##1 !o_visual)
      else $error("alarm did not clear");
   a_no_hi_alarm: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_no_ppm >= no_hi_reg) |=> hi_no_reg)
      else $error("NO high alarm missing");
   a_no_lo_alarm: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_no_ppm <= no_lo_reg) |=> lo_no_reg)
      else $error("NO low alarm missing");
   a_shut_entry: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_NORMAL && (shut_no_reg || shut_no2_reg))
      |=> state_reg == SAFE_SHUTOFF ##1 !o_delivery_en)
      else $error("shutoff not entered");
   a_no_early_ovr: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF && hold_cnt_reg < HOLD_CYC - 1)
      |=> state_reg != SAFE_OVERRIDE)
      else $error("override before hold elapsed");
   a_hold_restart: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF && !hold_pair) |=> hold_cnt_reg == 0)
      else $error("hold timer not restarted");
   a_ovr_flow: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_OVERRIDE)
      |=> o_delivery_en && o_disp_msg != DISP_SHUTOFF)
      else $error("override flow or display wrong");
   // integer readings: exceeding by one ppm means strictly above
   a_no2_trip: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_no2_ppm > no2_hi_reg) |=> shut_no2_reg)
      else $error("NO2 shutoff compare missing");
   a_shut_no_flow: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF) |=> !o_delivery_en)
      else $error("gas flows during shutoff");
   a_shut_beep: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF) |=> o_audible)
      else $error("shutoff without audible alarm");
   a_shut_disp: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF && !phase_reg)
      |=> o_disp_msg == DISP_SHUTOFF)
      else $error("shutoff message missing");
   a_ovr_msg: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_OVERRIDE && !phase_reg)
      |=> o_disp_msg == DISP_OVERRIDE)
      else $error("override message missing");
   a_ovr_latch: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_OVERRIDE) |=> state_reg == SAFE_OVERRIDE)
      else $error("override left without power cycle");
   a_wrong_pair: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state_reg == SAFE_SHUTOFF && !hold_pair)
      |=> state_reg == SAFE_SHUTOFF)
      else $error("override without the button pair");
endmodule
`default_nettype wire

// >>> verification/gas_panel_model.sv
// front panel model: sensor readings and the three buttons
`timescale 1ns/1ps
`default_nettype none
module gas_panel_model (
   input  wire logic        i_clk,     // clock
   input  wire logic [15:0] i_no,      // wanted NO reading
   input  wire logic [15:0] i_no2,     // wanted NO2 reading
   input  wire logic [2:0]  i_btn,     // back, NO silence, NO2 silence
   output logic [15:0]      o_no,      // NO reading to device
   output logic [15:0]      o_no2,     // NO2 reading to device
   output logic             o_back,    // back held
   output logic             o_sil_no,  // NO silence held
   output logic             o_sil_no2  // NO2 silence held
);
   // readings and buttons change only just after an edge
   always @(posedge i_clk) begin
      o_no <= i_no;
      o_no2 <= i_no2;
      {o_back, o_sil_no, o_sil_no2} <= i_btn;
   end
endmodule
`default_nettype wire

// >>> verification/test_gas_alarm_safety_interlock.sv
// self-checking bench for the gas alarm and safety interlock
`timescale 1ns/1ps
`default_nettype none
module test_gas_alarm_safety_interlock;
   import gas_alarm_pkg::*;
   logic        clk = 0, rst_n = 0, rd = 0, wr = 0, bad;
   logic [3:0]  a = 4'h0;
   logic [31:0] wd = 32'h0, d, rdd;
   logic [15:0] no = 16'h0, no2 = 16'h0, pno, pno2;
   logic [2:0]  btn = 3'h0;
   logic        back, sn, sn2, aud, vis, del, wreq;
   logic [1:0]  msg;
   int          n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hfcc8, v, v2;
   gas_panel_model i_gas_panel_model (.i_clk(clk), .i_no(no), .i_no2(no2),
      .i_btn(btn), .o_no(pno), .o_no2(pno2), .o_back(back),
      .o_sil_no(sn), .o_sil_no2(sn2));
   gas_alarm_safety_interlock #(.HOLD_CYC(20), .BLINK_CYC(4))
   i_gas_alarm_safety_interlock (.i_ref_clk(clk), .i_arst_n(rst_n),
      .i_no_ppm(pno), .i_no2_ppm(pno2), .i_btn_back(back),
      .i_btn_sil_no(sn), .i_btn_sil_no2(sn2), .i_avs_address(a),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdd),
      .o_avs_waitrequest(wreq), .o_audible(aud), .o_visual(vis),
      .o_delivery_en(del), .o_disp_msg(msg));
   always #4 clk = ~clk;
   // a hang is cut short well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [3:0] ad,
                      input logic [31:0] dw);
      @(posedge clk);
      a <= ad;
      wd <= dw;
      wr <= w;
      rd <= !w;
      // only the bench timeout ends a wait that never answers
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      d = rdd;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic cr(input logic [3:0] ad, input logic [31:0] e);
      bus(1'b0, ad, 32'h0);
      check(d, e);
   endtask
   task automatic setin(input int n1, input int n2);
      @(posedge clk);
      no <= 16'(n1);
      no2 <= 16'(n2);
      wt(6);
   endtask
   // any sight of the override message while holding sets bad
   task automatic hold(input logic [2:0] b, input int n);
      @(posedge clk);
      btn <= b;
      bad = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if (msg === DISP_OVERRIDE) bad = 1'b1;
      end
   endtask
   task automatic dchk(input logic [1:0] m);
      int nm, nr, nb;
      nm = 0;
      nr = 0;
      nb = 0;
      repeat (16) begin
         @(posedge clk);
         if (msg === m) nm++;
         else if (msg === DISP_READINGS) nr++;
         else nb++;
      end
      check(32'(nm > 0 && nr > 0 && nb == 0), 32'h1);
   endtask
   task automatic prst();
      @(posedge clk);
      rst_n <= 1'b0;
      wt(5);
      rst_n <= 1'b1;
      wt(6);
   endtask
   function automatic logic [31:0] alarm(input int n1, input int n2);
      return 32'(n1 >= 100 || n1 <= 20 || n2 >= 10);
   endfunction
   initial begin
      prst();
      cr(4'h0, 32'h0);
      cr(4'h1, 32'h50);
      cr(4'h2, 32'h0);
      cr(4'h3, 32'h5);
      bus(1'b1, 4'h7, 32'h1234);
      cr(4'h7, 32'h0);
      bus(1'b1, 4'h1, 32'hffff_0032);
      cr(4'h1, 32'h32);
      $display("test registers done");
      setin(50, 0);
      check({aud, vis}, 2'b11);
      bus(1'b1, 4'h1, 32'd51);
      setin(50, 0);
      check(vis, 1'b0);
      bus(1'b1, 4'h2, 32'd50);
      setin(50, 0);
      check({aud, vis}, 2'b11);
      bus(1'b1, 4'h2, 32'd49);
      setin(50, 0);
      check(vis, 1'b0);
      setin(50, 5);
      check({aud, vis}, 2'b11);
      cr(4'h4, 32'h4);
      cr(4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      cr(4'h0, 32'h1);
      setin(50, 5);
      check({aud, vis}, 2'b01);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b1, 4'h3, 32'd6);
      setin(50, 5);
      check(vis, 1'b0);
      $display("test thresholds done");
      bus(1'b1, 4'h1, 32'd100);
      bus(1'b1, 4'h2, 32'd20);
      bus(1'b1, 4'h3, 32'd10);
      repeat (40) begin
         v = {$random(seed)} % 105;
         v2 = {$random(seed)} % 11;
         setin(v, v2);
         check(vis, alarm(v, v2));
         check(aud, alarm(v, v2));
      end
      $display("test random done");
      setin(104, 0);
      check(del, 1'b1);
      setin(105, 0);
      check({aud, del}, 2'b10);
      cr(4'h4, 32'h9);
      dchk(DISP_SHUTOFF);
      hold(3'b011, 30);
      hold(3'b000, 2);
      check(del, 1'b0);
      hold(3'b110, 15);
      hold(3'b000, 1);
      hold(3'b110, 15);
      hold(3'b000, 2);
      check(del, 1'b0);
      hold(3'b110, 17);
      check(bad, 1'b0);
      hold(3'b110, 10);
      hold(3'b000, 3);
      check(del, 1'b1);
      bus(1'b0, 4'h4, 32'h0);
      check(d[4], 1'b1);
      dchk(DISP_OVERRIDE);
      $display("test no shutoff done");
      prst();
      check(del, 1'b0);
      cr(4'h4, 32'h9);
      setin(40, 0);
      prst();
      check({aud, vis, del}, 3'b001);
      setin(40, 6);
      check({aud, del}, 2'b10);
      cr(4'h4, 32'h2c);
      hold(3'b110, 30);
      hold(3'b000, 2);
      check(del, 1'b0);
      hold(3'b011, 30);
      hold(3'b000, 3);
      check(del, 1'b1);
      dchk(DISP_OVERRIDE);
      $display("test no2 shutoff done");
      final_report();
   end
endmodule
`default_nettype wire
